// [rtl/otpx_dev.sv]
// device end: otp program engine and xip entry/exit
//
// Notes on behaviour
// R1 - program needs write enable latch set
// R2 - controller raises select after last byte
// R3 - frame: command, three address bytes, data
// R4 - address bits taken on clock rising edge
// R5 - select rise starts timed program
// R6 - no wrap, 65 bytes max, rest dropped
// R7 - 64 data bytes plus control byte
// R8 - busy set, latch cleared, busy clears after
// R9 - timeout clears latch, sets fail flag
// R10 - misaligned select rise: nothing happens
// R11 - lock bit zero is permanent
// R12 - locked: ignore, keep latch, flag 1,4
// R13 - xip entry: config bit3 low, confirm 0
// R14 - in xip frames start with address
// R15 - confirm 1 leaves xip, restores bit3
// R16 - basic variant: confirm 0 enters xip
// R17 - nonvolatile select boots into xip
// R18 - confirm sampled io0 first dummy clock
// R19 - other io lines ignored in dummy
// R20 - reset pin reloads xip from nonvolatile select, only deselected
// R21 - exit: io0 high 7/13/25 clocks
// R22 - exit leaves program operation alone
// R23 - flag bit4 marks program refusal
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module otpx_dev (
  otpx_link_if.dev         link,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclk_en,
  input  wire logic [1:0]  proto,
  input  wire logic [2:0]  nvcr_xip,
  input  wire logic        basic_xip,
  input  wire logic        rst_pin_en,
  input  wire logic        cell_ready,
  input  wire logic [6:0]  otp_rd_idx,
  output logic      [7:0]  otp_rd_data,
  output logic      [7:0]  flag_status,
  output logic             wip,
  output logic             wel,
  output logic             xip_active,
  output logic      [7:0]  vcr
);
  typedef enum logic [2:0] {D_IDLE, D_CMD, D_ADDR, D_DATA, D_DUMMY, D_END, D_SKIP} otpx_dst_e;

  typedef struct packed {
    logic             cs1;
    logic             cs2;
    logic             csd;
    logic             ck1;
    logic             ck2;
    logic             ckd;
    logic             rp1;
    logic             rp2;
    logic [3:0]       io1;
    logic [3:0]       io2;
    logic             init;
    otpx_dst_e        st;
    logic [3:0]       bc;
    logic [7:0]       cmd;
    logic [7:0]       vby;
    logic [15:0]      ahi;
    logic [1:0]       ab;
    logic [6:0]       idx;
    logic [6:0]       nb;
    logic [64:0]      msk;
    logic [64:0][7:0] stg;
    logic [64:0][7:0] otp;
    logic             wel;
    logic             wip;
    logic             fail;
    logic             prot;
    logic             xip;
    logic [7:0]       vcr;
    logic [15:0]      tmr;
  } otpx_dev_s;

  otpx_dev_s st_r;
  otpx_dev_s st_nxt;

  always_comb begin
    logic [7:0] b;
    logic [3:0] w;
    logic [3:0] nbc;
    logic       rise;
    logic       csf;
    logic       csr;
    logic       bd;
    logic       nv_on;
    st_nxt = st_r;
    b      = 8'h00;
    w      = otpx_pkg::lanes(proto);
    nbc    = st_r.bc + w;
    bd     = (nbc == 4'h8);
    rise   = st_r.ck2 & ~st_r.ckd;
    csf    = ~st_r.cs2 & st_r.csd;
    csr    = st_r.cs2 & ~st_r.csd;
    nv_on  = (nvcr_xip != otpx_pkg::NV_XIP_OFF);
    // pins cross in through two flops
    st_nxt.cs1 = link.cs_n;
    st_nxt.cs2 = st_r.cs1;
    st_nxt.csd = st_r.cs2;
    st_nxt.ck1 = link.sclk;
    st_nxt.ck2 = st_r.ck1;
    st_nxt.ckd = st_r.ck2;
    st_nxt.rp1 = link.rst_n;
    st_nxt.rp2 = st_r.rp1;
    st_nxt.io1 = link.io;
    st_nxt.io2 = st_r.io1;
    case (proto)
      otpx_pkg::PR_DUAL: b = {st_r.vby[5:0], st_r.io2[1:0]};
      otpx_pkg::PR_QUAD: b = {st_r.vby[3:0], st_r.io2};
      default:           b = {st_r.vby[6:0], st_r.io2[0]};
    endcase
    // strap caught once after reset release
    if (!st_r.init) begin
      st_nxt.init = 1'b1;
      st_nxt.xip  = nv_on; // [R17]
    end
    if (csf) begin
      st_nxt.st = st_r.xip ? D_ADDR : D_CMD; // [R14]
      st_nxt.bc = 4'h0;
      st_nxt.ab = 2'h0;
      st_nxt.nb = 7'h00;
    end else if (csr) begin
      st_nxt.st = D_IDLE;
      if (st_r.bc == 4'h0) begin // [R10]
        case (st_r.st)
          D_END: begin
            if (st_r.cmd == otpx_pkg::CMD_WREN && !st_r.wip)
              st_nxt.wel = 1'b1;
            if (st_r.cmd == otpx_pkg::CMD_WRDI && !st_r.wip)
              st_nxt.wel = 1'b0;
            if (st_r.cmd == otpx_pkg::CMD_CLRFLAG) begin
              st_nxt.fail = 1'b0;
              st_nxt.prot = 1'b0;
            end
          end
          D_DATA: begin
            if (st_r.nb != 7'h00 && st_r.cmd == otpx_pkg::CMD_PROG
                && !st_r.wip && st_r.wel) begin // [R1]
              if (!st_r.otp[otpx_pkg::LOCK_IDX][otpx_pkg::LOCK_BIT]) begin
                st_nxt.prot = 1'b1; // [R12]
                st_nxt.fail = 1'b1; // [R23]
              end else begin
                st_nxt.wip = 1'b1; // [R5] [R8]
                st_nxt.wel = 1'b0; // [R8]
                st_nxt.tmr = otpx_pkg::PROG_CYC;
              end
            end
            if (st_r.nb != 7'h00 && st_r.cmd == otpx_pkg::CMD_WRVCR
                && !st_r.wip && st_r.wel) begin
              st_nxt.vcr = st_r.vby;
              st_nxt.wel = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end else if (rise && !st_r.cs2) begin
      // bits taken on the rising link clock
      st_nxt.vby = b; // [R4]
      st_nxt.bc  = bd ? 4'h0 : nbc;
      case (st_r.st)
        D_CMD: if (bd) begin // [R3]
          st_nxt.cmd = b;
          case (b)
            otpx_pkg::CMD_PROG: begin
              st_nxt.st = D_ADDR;
              // a running program keeps its staged bytes
              if (!st_r.wip)
                st_nxt.msk = '0;
            end
            otpx_pkg::CMD_FREAD:   st_nxt.st = D_ADDR;
            otpx_pkg::CMD_WRVCR:   st_nxt.st = D_DATA;
            otpx_pkg::CMD_WREN,
            otpx_pkg::CMD_WRDI,
            otpx_pkg::CMD_CLRFLAG: st_nxt.st = D_END;
            default:               st_nxt.st = D_SKIP;
          endcase
        end
        D_ADDR: if (bd) begin
          st_nxt.ab  = st_r.ab + 2'h1;
          st_nxt.ahi = {st_r.ahi[7:0], b};
          if (st_r.ab == 2'h2) begin
            // any address above the control byte lands nowhere
            st_nxt.idx = (b[7] || st_r.ahi != 16'h0000) ? otpx_pkg::IDX_NONE : b[6:0];
            st_nxt.st  = (st_r.xip || st_r.cmd == otpx_pkg::CMD_FREAD) ? D_DUMMY : D_DATA;
          end
        end
        D_DATA: if (bd) begin
          if (st_r.nb != 7'h7F)
            st_nxt.nb = st_r.nb + 7'h01;
          if (st_r.cmd == otpx_pkg::CMD_PROG && !st_r.wip
              && st_r.idx <= otpx_pkg::LOCK_IDX && st_r.nb < otpx_pkg::OTP_BYTES) begin
            st_nxt.stg[st_r.idx] = b; // [R6] [R7]
            st_nxt.msk[st_r.idx] = 1'b1;
          end
          if (st_r.idx != otpx_pkg::IDX_NONE)
            st_nxt.idx = st_r.idx + 7'h01; // [R6]
        end
        D_DUMMY: begin
          st_nxt.st = D_SKIP;
          // only io0 matters here, upper lanes are don't care
          if (st_r.xip && st_r.io2[0]) begin // [R18] [R19]
            st_nxt.xip = 1'b0; // [R15] [R21] [R22]
            st_nxt.vcr[otpx_pkg::VCR_XIP] = 1'b1; // [R15]
          end else if (!st_r.io2[0]
                       && (!st_r.vcr[otpx_pkg::VCR_XIP] || basic_xip)) begin
            st_nxt.xip = 1'b1; // [R13] [R16]
          end
        end
        D_END:   st_nxt.st = D_SKIP;
        default: ;
      endcase
    end
    // program timer; placed after the clear so a failure wins
    if (st_r.wip) begin
      if (st_r.tmr != 16'h0000) begin
        st_nxt.tmr = st_r.tmr - 16'h0001;
      end else begin
        st_nxt.wip = 1'b0; // [R8]
        if (cell_ready) begin
          for (int i = 0; i < 65; i++)
            if (st_r.msk[i])
              st_nxt.otp[i] = st_r.otp[i] & st_r.stg[i]; // [R11]
        end else begin
          st_nxt.wel  = 1'b0; // [R9]
          st_nxt.fail = 1'b1; // [R9]
        end
      end
    end
    // reset pin touches xip state, vcr and frame state only, never the program timer
    if (rst_pin_en && !st_r.rp2 && st_r.cs2) begin // [R20] [R22]
      st_nxt.xip = nv_on;
      st_nxt.vcr = otpx_pkg::VCR_RST;
      st_nxt.st  = D_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= '0;
      st_r.cs1 <= 1'b1;
      st_r.cs2 <= 1'b1;
      st_r.csd <= 1'b1;
      st_r.rp1 <= 1'b1;
      st_r.rp2 <= 1'b1;
      st_r.otp <= '1;
      st_r.vcr <= otpx_pkg::VCR_RST;
    end else if (pclk_en) begin
      st_r <= st_nxt;
    end
  end

  assign otp_rd_data = (otp_rd_idx <= otpx_pkg::LOCK_IDX) ? st_r.otp[otp_rd_idx] : 8'h00;
  assign flag_status = {~st_r.wip, 2'h0, st_r.fail, 2'h0, st_r.prot, 1'b0};
  assign wip         = st_r.wip;
  assign wel         = st_r.wel;
  assign xip_active  = st_r.xip;
  assign vcr         = st_r.vcr;
endmodule
`default_nettype wire

// [rtl/otpx_pkg.sv]
// shared constants for the otp program and xip link
package otpx_pkg;
  localparam logic [7:0] CMD_WREN    = 8'h06;
  localparam logic [7:0] CMD_WRDI    = 8'h04;
  localparam logic [7:0] CMD_CLRFLAG = 8'h50;
  localparam logic [7:0] CMD_PROG    = 8'h42;
  localparam logic [7:0] CMD_FREAD   = 8'h0B;
  localparam logic [7:0] CMD_WRVCR   = 8'h81;
  localparam logic [1:0] PR_EXT      = 2'h0;
  localparam logic [1:0] PR_DUAL     = 2'h1;
  localparam logic [1:0] PR_QUAD     = 2'h2;
  localparam logic [6:0] OTP_BYTES   = 7'h41;
  localparam logic [6:0] LOCK_IDX    = 7'h40;
  localparam logic [6:0] IDX_NONE    = 7'h7F;
  localparam int         LOCK_BIT    = 0;
  localparam int         FLG_READY   = 7;
  localparam int         FLG_FAIL    = 4;
  localparam int         FLG_PROT    = 1;
  localparam int         VCR_XIP     = 3;
  localparam logic [7:0] VCR_RST     = 8'hFF;
  localparam logic [2:0] NV_XIP_OFF  = 3'h7;
  localparam int         CLK_NS      = 50;
  localparam int         PROG_TIME_NS = 2000;
  localparam logic [15:0] PROG_CYC   = 16'((PROG_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam int         RST_NS      = 100;
  localparam logic [2:0] RST_CYC     = 3'((RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] SCLK_HALF   = 3'h4;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ADDR    = 8'h04;
  localparam logic [7:0] REG_TX      = 8'h08;
  localparam logic [7:0] REG_PROTO   = 8'h0C;
  localparam logic [7:0] REG_STAT    = 8'h10;
  localparam int         CT_NOCMD    = 8;
  localparam int         CT_ADDR     = 9;
  localparam int         CT_NB_LO    = 10;
  localparam int         CT_NB_HI    = 16;
  localparam int         CT_DUMMY    = 17;
  localparam int         CT_CONF     = 18;
  localparam int         CT_EXIT     = 19;
  localparam int         CT_RST      = 20;

  function automatic logic [3:0] lanes(input logic [1:0] p);
    case (p)
      PR_DUAL: lanes = 4'h2;
      PR_QUAD: lanes = 4'h4;
      default: lanes = 4'h1;
    endcase
  endfunction

  function automatic logic [4:0] byte_clks(input logic [1:0] p);
    case (p)
      PR_DUAL: byte_clks = 5'h04;
      PR_QUAD: byte_clks = 5'h02;
      default: byte_clks = 5'h08;
    endcase
  endfunction

  function automatic logic [4:0] exit_clks(input logic [1:0] p);
    case (p)
      PR_DUAL: exit_clks = 5'h0D;
      PR_QUAD: exit_clks = 5'h07;
      default: exit_clks = 5'h19;
    endcase
  endfunction
endpackage

// [rtl/otpx_link_if.sv]
// serial link between memory controller and otp/xip device
`timescale 1ns/1ps
`default_nettype none
interface otpx_link_if;
  logic       cs_n;
  logic       sclk;
  logic       rst_n;
  logic [3:0] io_o;
  logic [3:0] io_oe;
  logic [3:0] io;
  // undriven lines read low
  assign io = io_o & io_oe;
  modport host (output cs_n, output sclk, output rst_n, output io_o, output io_oe);
  modport dev  (input cs_n, input sclk, input rst_n, input io);
endinterface
`default_nettype wire

// [rtl/otpx_host.sv]
// controller end: apb-driven frame generator for the serial link
`timescale 1ns/1ps
`default_nettype none
module otpx_host (
  otpx_link_if.host        link,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [2:0] {H_IDLE, H_RST, H_SEL, H_LOAD, H_LOW, H_HIGH, H_DESEL} otpx_hst_e;
  localparam logic [2:0] SG_CMD = 3'h0;
  localparam logic [2:0] SG_A0  = 3'h3;
  localparam logic [2:0] SG_DAT = 3'h4;
  localparam logic [2:0] SG_DUM = 3'h5;
  localparam logic [2:0] SG_EXI = 3'h6;

  typedef struct packed {
    logic [1:0]  proto;
    logic [23:0] addr;
    logic [20:0] ctl;
    logic [7:0]  tx;
    logic        txv;
    otpx_hst_e   st;
    logic [2:0]  seg;
    logic [7:0]  sh;
    logic [4:0]  cl;
    logic [2:0]  dv;
    logic [6:0]  nl;
    logic        cs_n;
    logic        sclk;
    logic        rst_n;
    logic [31:0] prd;
  } otpx_host_s;

  otpx_host_s st_r;
  otpx_host_s st_nxt;
  logic       mapped;
  logic       take;

  assign mapped  = paddr == otpx_pkg::REG_CTRL || paddr == otpx_pkg::REG_ADDR
                || paddr == otpx_pkg::REG_TX || paddr == otpx_pkg::REG_PROTO
                || paddr == otpx_pkg::REG_STAT;
  // control writes stall while a frame runs, tx writes while a byte is still pending
  assign pready  = !(pwrite && ((paddr == otpx_pkg::REG_CTRL && st_r.st != H_IDLE)
                             || (paddr == otpx_pkg::REG_TX && st_r.txv)));
  assign take    = psel && penable && pready;
  assign pslverr = take && !mapped;
  assign prdata  = st_r.prd;

  always_comb begin
    logic       tick;
    logic       ex;
    logic [3:0] w;
    st_nxt = st_r;
    tick   = (st_r.dv == otpx_pkg::SCLK_HALF - 3'h1);
    ex     = st_r.ctl[otpx_pkg::CT_EXIT];
    w      = otpx_pkg::lanes(st_r.proto);
    st_nxt.dv = (tick || st_r.st == H_IDLE || st_r.st == H_LOAD) ? 3'h0 : st_r.dv + 3'h1;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        otpx_pkg::REG_CTRL:  st_nxt.prd = {11'h000, st_r.ctl};
        otpx_pkg::REG_ADDR:  st_nxt.prd = {8'h00, st_r.addr};
        otpx_pkg::REG_PROTO: st_nxt.prd = {30'h0000_0000, st_r.proto};
        otpx_pkg::REG_STAT:  st_nxt.prd = {30'h0000_0000, st_r.txv, st_r.st != H_IDLE};
        default:             st_nxt.prd = 32'h0000_0000;
      endcase
    end
    if (take && pwrite) begin
      case (paddr)
        otpx_pkg::REG_CTRL:  st_nxt.ctl = pwdata[20:0];
        otpx_pkg::REG_ADDR:  st_nxt.addr = pwdata[23:0];
        otpx_pkg::REG_PROTO: st_nxt.proto = pwdata[1:0];
        otpx_pkg::REG_TX: begin
          st_nxt.tx  = pwdata[7:0];
          st_nxt.txv = 1'b1;
        end
        default: ;
      endcase
    end
    case (st_r.st)
      H_IDLE: if (take && pwrite && paddr == otpx_pkg::REG_CTRL) begin
        if (pwdata[otpx_pkg::CT_RST]) begin
          st_nxt.st    = H_RST;
          st_nxt.rst_n = 1'b0;
        end else begin
          st_nxt.st   = H_SEL;
          st_nxt.cs_n = 1'b0;
          st_nxt.seg  = SG_CMD;
          st_nxt.nl   = pwdata[otpx_pkg::CT_NB_HI:otpx_pkg::CT_NB_LO];
        end
      end
      H_RST: if (st_r.dv == otpx_pkg::RST_CYC - 3'h1) begin
        st_nxt.st    = H_IDLE;
        st_nxt.rst_n = 1'b1;
      end
      H_SEL: if (tick)
        st_nxt.st = H_LOAD;
      H_LOAD: begin
        st_nxt.cl = otpx_pkg::byte_clks(st_r.proto);
        st_nxt.st = H_LOW;
        if (st_r.seg != SG_DAT)
          st_nxt.seg = st_r.seg + 3'h1;
        case (st_r.seg)
          SG_CMD: begin
            st_nxt.sh = st_r.ctl[7:0];
            if (ex || st_r.ctl[otpx_pkg::CT_NOCMD])
              st_nxt.st = H_LOAD;
          end
          3'h1, 3'h2, SG_A0: begin
            st_nxt.sh = st_r.addr[8'(23 - 8 * (int'(st_r.seg) - 1)) -: 8]; // [R3]
            if (ex || !st_r.ctl[otpx_pkg::CT_ADDR])
              st_nxt.st = H_LOAD;
          end
          SG_DAT: begin
            st_nxt.sh = st_r.tx;
            if (ex || st_r.nl == 7'h00) begin
              st_nxt.st  = H_LOAD;
              st_nxt.seg = SG_DUM;
            end else if (st_r.txv) begin
              st_nxt.txv = 1'b0;
              st_nxt.nl  = st_r.nl - 7'h01;
            end else begin
              st_nxt.st = H_LOAD;
            end
          end
          SG_DUM: begin
            // one extra clock carries the confirm bit on io0
            st_nxt.sh = {8{st_r.ctl[otpx_pkg::CT_CONF]}}; // [R18] [R13]
            st_nxt.cl = 5'h01;
            if (ex || !st_r.ctl[otpx_pkg::CT_DUMMY])
              st_nxt.st = H_LOAD;
          end
          SG_EXI: begin
            st_nxt.sh = 8'hFF;
            st_nxt.cl = otpx_pkg::exit_clks(st_r.proto); // [R21]
            if (!ex)
              st_nxt.st = H_LOAD;
          end
          default: begin
            st_nxt.st  = H_DESEL;
            st_nxt.seg = st_r.seg;
          end
        endcase
      end
      H_LOW: if (tick) begin
        st_nxt.st   = H_HIGH;
        st_nxt.sclk = 1'b1;
      end
      H_HIGH: if (tick) begin
        st_nxt.sclk = 1'b0;
        // ones shift in so exit frames keep io0 high
        st_nxt.sh   = (st_r.sh << w) | ~(8'hFF << w);
        st_nxt.cl   = st_r.cl - 5'h01;
        st_nxt.st   = (st_r.cl == 5'h01) ? H_LOAD : H_LOW;
      end
      H_DESEL: begin
        st_nxt.cs_n = 1'b1; // [R2]
        if (tick)
          st_nxt.st = H_IDLE;
      end
      default: st_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= '0;
      st_r.cs_n  <= 1'b1;
      st_r.rst_n <= 1'b1;
    end else if (pclk_en) begin
      st_r <= st_nxt;
    end
  end

  assign link.cs_n  = st_r.cs_n;
  assign link.sclk  = st_r.sclk;
  assign link.rst_n = st_r.rst_n;
  always_comb begin
    case (st_r.proto)
      otpx_pkg::PR_DUAL: link.io_o = {2'h0, st_r.sh[7:6]};
      otpx_pkg::PR_QUAD: link.io_o = st_r.sh[7:4];
      default:           link.io_o = {3'h0, st_r.sh[7]};
    endcase
    link.io_oe = st_r.cs_n ? 4'h0 : ~(4'hF << otpx_pkg::lanes(st_r.proto));
  end
endmodule
`default_nettype wire

// [sim/otpx_chk.sv]
// link and device status assertions
`timescale 1ns/1ps
`default_nettype none
module otpx_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       rst_n,
  input wire logic [3:0] io_oe,
  input wire logic       wip,
  input wire logic       wel,
  input wire logic       xip_active,
  input wire logic [7:0] vcr,
  input wire logic [7:0] flag_status
);
  localparam int PROG = int'(otpx_pkg::PROG_CYC);
  // busy run length, judged when busy ends
  logic [7:0] run_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 8'h00;
    end else begin
      run_r <= wip ? run_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sel_rise_a: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
    else $error("select rose with clock high");
  clk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("clock moved outside a frame");
  io_idle_a: assert property (cs_n |-> io_oe == 4'h0)
    else $error("data driven while deselected");
  prog_sel_a: assert property ($rose(wip) |-> cs_n)
    else $error("program started inside a frame");
  prog_wel_a: assert property ($rose(wip) |-> $past(wel))
    else $error("program started without latch");
  wel_drop_a: assert property ($rose(wip) |-> ##[0:3] !wel)
    else $error("latch kept during program");
  prog_time_a: assert property ($fell(wip) |-> run_r >= 8'(PROG - 1) && run_r <= 8'(PROG + 1))
    else $error("program time wrong");
  busy_flag_a: assert property (flag_status[7] == !wip && !(wip && wel))
    else $error("ready flag disagrees with busy");
  lock_err_a: assert property ($rose(flag_status[1]) |-> flag_status[4] && wel)
    else $error("protect flag without fail or latch");
  fail_why_a: assert property ($rose(flag_status[4]) |-> flag_status[1] || !wel)
    else $error("fail flag with latch still set");
  xip_vcr_a: assert property ($fell(xip_active) |-> ##[0:3] vcr[3])
    else $error("xip left without config bit restored");
  rst_sel_a: assert property (!rst_n |-> cs_n)
    else $error("reset pin pulsed while selected");
endmodule
`default_nettype wire

// [sim/otpx_test.sv]
// bench: apb-driven frames through both link ends
`timescale 1ns/1ps
`default_nettype none
module otpx_test;
  localparam logic [31:0] F_NOCMD = 32'h0000_0100;
  localparam logic [31:0] F_ADDR  = 32'h0000_0200;
  localparam logic [31:0] F_DUMMY = 32'h0002_0000;
  localparam logic [31:0] F_CONF  = 32'h0004_0000;
  localparam logic [31:0] F_EXIT  = 32'h0008_0000;
  localparam logic [31:0] F_RST   = 32'h0010_0000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        basic_xip, rst_pin_en, cell_ready, wip, wel, xip_active;
  logic [7:0]  paddr, otp_rd_data, flag_status, vcr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  proto;
  logic [2:0]  nvcr_xip;
  logic [6:0]  otp_rd_idx;
  logic [7:0]  exp_otp [0:64];
  int          fail_count, checks_done;
  otpx_link_if link ();
  otpx_host i_otpx_host (.link, .pclk, .presetn, .pclk_en(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  otpx_dev i_otpx_dev (.link, .pclk, .presetn, .pclk_en(1'b1), .proto, .nvcr_xip, .basic_xip,
    .rst_pin_en, .cell_ready, .otp_rd_idx, .otp_rd_data, .flag_status, .wip, .wel,
    .xip_active, .vcr);
  otpx_chk i_otpx_chk (.pclk, .presetn, .cs_n(link.cs_n), .sclk(link.sclk),
    .rst_n(link.rst_n), .io_oe(link.io_oe), .wip, .wel, .xip_active, .vcr, .flag_status);
  always #25 pclk = ~pclk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] cw(input logic [7:0] op, input int nb, input logic [31:0] fl);
    return fl | {15'h0000, 7'(nb), 10'h000} | {24'h00_0000, op};
  endfunction
  // waits out the busy poll, then the longest device reaction
  task automatic frame(input logic [31:0] c, input logic [23:0] a, input logic [7:0] d);
    apb(1'b1, otpx_pkg::REG_ADDR, {8'h00, a});
    apb(1'b1, otpx_pkg::REG_CTRL, c);
    for (int i = 0; i < int'(c[16:10]); i++) begin
      apb(1'b1, otpx_pkg::REG_TX, {24'h00_0000, d ^ 8'(i)});
    end
    rd = 32'h0000_0001;
    while (rd[0] === 1'b1) begin
      apb(1'b0, otpx_pkg::REG_STAT, 32'h0000_0000);
    end
    repeat (int'(otpx_pkg::PROG_CYC) + 16) @(posedge pclk);
  endtask
  task automatic prog(input int s, input int n, input logic [7:0] d, input logic ok);
    frame(cw(otpx_pkg::CMD_PROG, n, F_ADDR), 24'(s), d);
    for (int i = 0; i < n; i++) begin
      if (ok && s + i <= 64) exp_otp[s + i] &= d ^ 8'(i);
    end
  endtask
  task automatic wren;
    frame(cw(otpx_pkg::CMD_WREN, 0, 32'h0), 24'h0, 8'h00);
  endtask
  task automatic setp(input logic [1:0] p);
    apb(1'b1, otpx_pkg::REG_PROTO, {30'h0000_0000, p});
    proto <= p;
    apb(1'b0, otpx_pkg::REG_PROTO, 32'h0000_0000);
    check(rd, {30'h0000_0000, p}, "proto readback");
  endtask
  task automatic stat(input logic ew, input logic ex, input logic [7:0] ef, input string what);
    check({22'h00_0000, wel, xip_active, flag_status}, {22'h00_0000, ew, ex, ef}, what);
  endtask
  task automatic chk_otp;
    for (int i = 0; i <= 64; i++) begin
      otp_rd_idx <= 7'(i);
      @(posedge pclk);
      check({24'h00_0000, otp_rd_data}, {24'h00_0000, exp_otp[i]}, "otp byte");
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // about ten times the expected run
  initial begin
    #5_000_000;
    fail_count++;
    $display("MISMATCH %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    proto = otpx_pkg::PR_EXT;
    nvcr_xip = otpx_pkg::NV_XIP_OFF;
    basic_xip = 1'b0;
    rst_pin_en = 1'b0;
    cell_ready = 1'b1;
    otp_rd_idx = 7'h00;
    fail_count = 0;
    checks_done = 0;
    for (int i = 0; i <= 64; i++) exp_otp[i] = 8'hFF;
    do_reset();
    stat(1'b0, 1'b0, 8'h80, "reset status");
    check({24'h00_0000, vcr}, {24'h00_0000, otpx_pkg::VCR_RST}, "reset vcr");
    apb(1'b0, 8'h40, 32'h0000_0000);
    check({err, rd[30:0]}, 32'h8000_0000, "unmapped access");
    prog(0, 1, 8'h00, 1'b0);
    stat(1'b0, 1'b0, 8'h80, "no latch, no program");
    wren();
    frame(cw(otpx_pkg::CMD_WRDI, 0, 32'h0), 24'h0, 8'h00);
    stat(1'b0, 1'b0, 8'h80, "latch cleared");
    for (int p = 0; p < 3; p++) begin
      setp(2'(p));
      wren();
      stat(1'b1, 1'b0, 8'h80, "latch set");
      prog(2 * p, 2, 8'hA5 + 8'(p), 1'b1);
      stat(1'b0, 1'b0, 8'h80, "after program");
    end
    chk_otp();
    $display("test program per protocol done");
    cell_ready <= 1'b0;
    wren();
    prog(10, 1, 8'h00, 1'b0);
    stat(1'b0, 1'b0, 8'h90, "timeout fail");
    cell_ready <= 1'b1;
    frame(cw(otpx_pkg::CMD_CLRFLAG, 0, 32'h0), 24'h0, 8'h00);
    wren();
    frame(cw(otpx_pkg::CMD_PROG, 1, F_ADDR | F_DUMMY), 24'h00_000C, 8'h00);
    stat(1'b1, 1'b0, 8'h80, "partial byte ignored");
    prog(0, 66, 8'hF3, 1'b1);
    stat(1'b0, 1'b0, 8'h80, "long program");
    chk_otp();
    $display("test timeout and overflow done");
    wren();
    prog(64, 1, 8'hFE, 1'b1);
    wren();
    prog(20, 1, 8'h00, 1'b0);
    stat(1'b1, 1'b0, 8'h92, "locked refusal");
    chk_otp();
    frame(cw(otpx_pkg::CMD_CLRFLAG, 0, 32'h0), 24'h0, 8'h00);
    $display("test lock done");
    for (int p = 0; p < 3; p++) begin
      setp(2'(p));
      wren();
      frame(cw(otpx_pkg::CMD_WRVCR, 1, 32'h0), 24'h0, 8'hF7);
      check({24'h00_0000, vcr}, 32'h0000_00F7, "vcr written");
      frame(cw(otpx_pkg::CMD_FREAD, 0, F_ADDR | F_DUMMY), 24'h00_0100, 8'h00);
      stat(1'b0, 1'b1, 8'h80, "xip entered");
      frame(cw(8'h00, 0, F_NOCMD | F_ADDR | F_DUMMY), 24'h00_0200, 8'h00);
      stat(1'b0, 1'b1, 8'h80, "xip kept");
      frame(cw(8'h00, 0, F_EXIT), 24'h0, 8'h00);
      check({23'h00_0000, xip_active, vcr}, 32'h0000_00FF, "exit sequence");
    end
    basic_xip <= 1'b1;
    setp(otpx_pkg::PR_EXT);
    frame(cw(otpx_pkg::CMD_FREAD, 0, F_ADDR | F_DUMMY), 24'h0, 8'h00);
    check({23'h00_0000, xip_active, vcr}, 32'h0000_01FF, "basic entry");
    frame(cw(8'h00, 0, F_NOCMD | F_ADDR | F_DUMMY | F_CONF), 24'h0, 8'h00);
    stat(1'b0, 1'b0, 8'h80, "confirm exit");
    basic_xip <= 1'b0;
    $display("test xip entry and exit done");
    nvcr_xip <= 3'h3;
    do_reset();
    stat(1'b0, 1'b1, 8'h80, "boot in xip");
    rst_pin_en <= 1'b1;
    frame(cw(8'h00, 0, F_NOCMD | F_ADDR | F_DUMMY | F_CONF), 24'h0, 8'h00);
    stat(1'b0, 1'b0, 8'h80, "left boot xip");
    frame(cw(8'h00, 0, F_RST), 24'h0, 8'h00);
    stat(1'b0, 1'b1, 8'h80, "pin restores xip");
    $display("test boot and reset pin done");
    report_and_stop();
  end
endmodule
`default_nettype wire
